// ===== core/icra_core.sv
/*
  indirect configuration register access over the serial management
  link: index and data registers, paired writes and auto-step access, mode
  split between lightly managed and unmanaged operation.
  assumes strobe period well above four clk_sys cycles and straps
  steady from reset release.
*/
`timescale 1ns/1ps
module icra_core
  import icra_pkg::*;
#(
  parameter int ADDR_W = CFG_ADDR_W
)
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // serial management link
  input  wire logic         ssi_strobe,
  input  wire logic         ssi_datain,
  output logic              ssi_dataout,
  output logic              ssi_dataout_oe,
  // straps: {eeprom_en_n, unmanaged, dev_id[2:0]}
  input  wire logic [4:0]   strap_pins,
  // eeprom boot loader write port
  input  wire logic         eeprom_boot_done,
  input  wire logic         eeprom_wr_valid,
  input  wire logic [11:0]  eeprom_wr_addr,
  input  wire logic [7:0]   eeprom_wr_data,
  output logic              eeprom_wr_ready,
  // mode and control outputs
  output logic              unmanaged_mode,
  output logic              switching_enable,
  output logic              frame_path_enable,
  output logic              irq_path_enable,
  output logic              self_check_start,
  output logic [3:0]        cpu_port_number,
  // frame bytes from the link
  output logic [7:0]        frame_byte,
  output logic              frame_byte_valid,
  output logic              frame_byte_is_ctrl,
  output logic              ctrl_frame_reject
);

  typedef struct packed {
    icra_state_e st;
    logic [4:0]  cnt;
    logic [15:0] sh;
    logic [2:0]  addr;
    logic [15:0] index;
    logic [15:0] rd_sh;
    logic [4:0]  rd_len;
    logic [1:0]  strap_cnt;
    logic        straps_taken;
    logic        unmanaged;
    logic        eeprom_en;
    logic [2:0]  dev_id;
    logic        check_go;
    logic [7:0]  fbyte;
    logic        fvalid;
    logic        fctrl;
    logic        reject;
  } icra_core_s;

  icra_core_s r_r;
  icra_core_s r_nxt;

  icra_pin_if pins ();

  icra_pin_sampler icra_pin_sampler_i (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .ssi_strobe (ssi_strobe),
    .ssi_datain (ssi_datain),
    .strap_pins (strap_pins),
    .pins       (pins.sampler)
  );

  logic [7:0] cfg_mem [0:(1<<ADDR_W)-1];

  logic              core_we;
  logic [ADDR_W-1:0] core_wa;
  logic [7:0]        core_wd;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic [ADDR_W-1:0] idx_addr;
  logic [15:0]       sh_in;
  logic [4:0]        cnt_in;
  logic [4:0]        wlen;
  logic              boot_loading;
  logic              gcr_init;
  logic              gcr_init_r;

  // low index bits address the byte
  assign idx_addr     = r_r.index[ADDR_W-1:0];
  assign sh_in        = {r_r.sh[14:0], pins.data_bit};
  assign cnt_in       = r_r.cnt + 5'd1;
  assign boot_loading = r_r.unmanaged & r_r.eeprom_en & ~eeprom_boot_done;
  // array has no reset, so the init bit is shadowed in a flop
  assign gcr_init     = gcr_init_r;

  always_comb
  begin
    if (r_r.addr == REG_INDEX_ADDR || (r_r.addr == REG_DATA_ADDR &&
        r_r.index[IDX_PAIR_BIT]))
      wlen = WORD_BITS;
    else
      wlen = BYTE_BITS;
  end

  always_comb
  begin
    r_nxt        = r_r;
    r_nxt.fvalid = 1'b0;
    r_nxt.reject = 1'b0;
    r_nxt.check_go = 1'b0;
    core_we      = 1'b0;
    core_wa      = idx_addr;
    core_wd      = sh_in[7:0];
    // strap capture after release, with the power-up memory check pulsed in the same cycle
    if (!r_r.straps_taken)
    begin
      r_nxt.strap_cnt = r_r.strap_cnt + 2'd1;
      if (r_r.strap_cnt == STRAP_WAIT)
      begin
        r_nxt.straps_taken = 1'b1;
        r_nxt.eeprom_en    = ~pins.straps[4];
        r_nxt.unmanaged    = pins.straps[3];
        r_nxt.dev_id       = pins.straps[2:0];
        r_nxt.check_go     = 1'b1;
      end
    end
    unique case (r_r.st)
      ST_WR_HI:
      begin
        // high byte to address plus one
        core_we = 1'b1;
        core_wa = idx_addr + ADDR_W'(1);
        core_wd = r_r.sh[15:8];
        if (r_r.index[IDX_AUTO_BIT])
          r_nxt.index[ADDR_W-1:0] = idx_addr + ADDR_W'(2);
        r_nxt.st = ST_SKIP;
      end
      ST_IDLE, ST_SKIP: ;
      default:
      begin
        if (pins.strobe_rise)
        begin
          r_nxt.sh  = sh_in;
          r_nxt.cnt = cnt_in;
          unique case (r_r.st)
            ST_ID:
            begin
              if (cnt_in == ID_BITS)
              begin
                r_nxt.st  = (sh_in[2:0] == r_r.dev_id) ? ST_ADDR : ST_SKIP;
                r_nxt.cnt = '0;
              end
            end
            ST_ADDR:
            begin
              if (cnt_in == ADDR_BITS)
              begin
                r_nxt.addr = sh_in[2:0];
                r_nxt.st   = ST_RW;
                r_nxt.cnt  = '0;
              end
            end
            ST_RW:
            begin
              r_nxt.cnt = '0;
              // link locked out during eeprom boot
              if (boot_loading)
                r_nxt.st = ST_SKIP;
              else if (pins.data_bit)
              begin
                r_nxt.st = ST_RDATA;
                if (r_r.addr == REG_DATA_ADDR)
                begin
                  r_nxt.rd_sh  = {cfg_mem[idx_addr], 8'h00};
                  r_nxt.rd_len = BYTE_BITS;
                end
                else
                begin
                  r_nxt.rd_sh  = r_r.index;
                  r_nxt.rd_len = WORD_BITS;
                end
              end
              else
                r_nxt.st = ST_WDATA;
            end
            ST_WDATA:
            begin
              if (cnt_in == wlen)
              begin
                r_nxt.cnt = '0;
                r_nxt.st  = ST_SKIP;
                if (r_r.addr == REG_INDEX_ADDR)
                  r_nxt.index = sh_in & ~IDX_RSVD_MASK;
                else if (r_r.addr == REG_DATA_ADDR)
                begin
                  core_we = 1'b1;
                  if (r_r.index[IDX_PAIR_BIT])
                    r_nxt.st = ST_WR_HI;
                  else if (r_r.index[IDX_AUTO_BIT])
                    r_nxt.index[ADDR_W-1:0] = idx_addr + ADDR_W'(1);
                end
                else if (r_r.addr == REG_FRAME_ADDR ||
                         r_r.addr == REG_CTRL_ADDR)
                begin
                  // byte stream: stay for the next byte
                  r_nxt.st = ST_WDATA;
                  if (r_r.unmanaged)
                    r_nxt.reject = (r_r.addr == REG_CTRL_ADDR);
                  else
                  begin
                    r_nxt.fvalid = 1'b1;
                    r_nxt.fbyte  = sh_in[7:0];
                    r_nxt.fctrl  = (r_r.addr == REG_CTRL_ADDR);
                  end
                end
              end
            end
            ST_RDATA:
            begin
              r_nxt.rd_sh = {r_r.rd_sh[14:0], 1'b0};
              if (cnt_in == r_r.rd_len)
              begin
                r_nxt.st = ST_SKIP;
                if (r_r.addr == REG_DATA_ADDR && r_r.index[IDX_AUTO_BIT])
                  r_nxt.index[ADDR_W-1:0] = idx_addr + ADDR_W'(1);
              end
            end
            default: ;
          endcase
        end
      end
    endcase
    if (core_we && core_wa == GCR_IDX[ADDR_W-1:0] &&
        core_wd[GCR_CHECK_BIT])
      r_nxt.check_go = 1'b1;
    // start restarts, stop ends any command
    if (pins.start_det)
    begin
      r_nxt.st  = ST_ID;
      r_nxt.cnt = '0;
    end
    else if (pins.stop_det)
      r_nxt.st = ST_IDLE;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r_r       <= '0;
      r_r.st    <= ST_IDLE;
      r_r.index <= INDEX_RESET;
    end
    else
      r_r <= r_nxt;
  end

  // eeprom loads only while booting unmanaged
  assign eeprom_wr_ready = boot_loading & ~core_we;
  assign mem_we = core_we | (eeprom_wr_valid & eeprom_wr_ready);
  assign mem_wa = core_we ? core_wa : eeprom_wr_addr[ADDR_W-1:0];
  assign mem_wd = core_we ? core_wd : eeprom_wr_data;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      gcr_init_r <= 1'b0;
    else if (mem_we && mem_wa == GCR_IDX[ADDR_W-1:0])
      gcr_init_r <= mem_wd[GCR_INIT_BIT];
  end

  // no reset on the array: contents come from boot or software
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      cfg_mem[mem_wa] <= mem_wd;
  end

  assign ssi_dataout        = r_r.rd_sh[15];
  assign ssi_dataout_oe     = (r_r.st == ST_RDATA);
  assign unmanaged_mode     = r_r.unmanaged;
  // managed mode waits for init bit
  assign switching_enable   = r_r.straps_taken & (r_r.unmanaged | gcr_init);
  assign frame_path_enable  = r_r.straps_taken & ~r_r.unmanaged;
  assign irq_path_enable    = r_r.straps_taken & ~r_r.unmanaged;
  assign self_check_start   = r_r.check_go;
  assign cpu_port_number    = CPU_PORT_NUM;
  assign frame_byte         = r_r.fbyte;
  assign frame_byte_valid   = r_r.fvalid;
  assign frame_byte_is_ctrl = r_r.fctrl;
  assign ctrl_frame_reject  = r_r.reject;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_data_wr;
    r_r.st == ST_WDATA && pins.strobe_rise && cnt_in == wlen &&
    r_r.addr == REG_DATA_ADDR && !pins.start_det && !pins.stop_det;
  endsequence

  sequence s_ctrl_unmanaged;
    r_r.st == ST_WDATA && pins.strobe_rise && cnt_in == BYTE_BITS &&
    r_r.addr == REG_CTRL_ADDR && r_r.unmanaged;
  endsequence

  AST_INDEX_RSVD_ZERO: assert property (
    (r_r.index & IDX_RSVD_MASK) == 16'h0000)
    else $error("reserved index bits not zero");

  AST_DATA_STORED: assert property (
    s_data_wr |=> cfg_mem[$past(idx_addr)] == $past(sh_in[7:0]))
    else $error("data write not stored at index");

  AST_PAIR_HIGH: assert property (
    s_data_wr ##0 r_r.index[IDX_PAIR_BIT] |=> core_we &&
      core_wa == $past(idx_addr) + ADDR_W'(1) ##1
      cfg_mem[$past(core_wa)] == $past(r_r.sh[15:8]))
    else $error("paired high byte not written at index plus one");

  AST_AUTOSTEP: assert property (
    s_data_wr ##0 r_r.index[IDX_AUTO_BIT] && !r_r.index[IDX_PAIR_BIT]
      |=> idx_addr == $past(idx_addr) + ADDR_W'(1))
    else $error("auto-step did not advance by one");

  AST_NO_STEP: assert property (
    s_data_wr ##0 !r_r.index[IDX_AUTO_BIT] |=> $stable(idx_addr) [*2])
    else $error("index moved without auto-step");

  AST_UNMANAGED_QUIET: assert property (
    r_r.unmanaged |-> !frame_path_enable && !irq_path_enable &&
      !frame_byte_valid)
    else $error("frame or interrupt path open in unmanaged mode");

  AST_CTRL_REJECT: assert property (
    s_ctrl_unmanaged |=> ctrl_frame_reject && !frame_byte_valid)
    else $error("control frame not rejected in unmanaged mode");

  AST_INIT_GATE: assert property (
    r_r.straps_taken && !r_r.unmanaged && !gcr_init |-> !switching_enable)
    else $error("switching before init complete");

  AST_POR_CHECK: assert property (
    $rose(r_r.straps_taken) |-> self_check_start ##1 !self_check_start)
    else $error("no single power-up self check pulse");

  AST_ID_FILTER: assert property (
    r_r.st == ST_ID && pins.strobe_rise && cnt_in == ID_BITS &&
      sh_in[2:0] != r_r.dev_id && !pins.start_det && !pins.stop_det
      |=> r_r.st == ST_SKIP)
    else $error("foreign device id accepted");

endmodule : icra_core

// ===== core/icra_pin_if.sv
/*
  carries synchronised link events from the pin sampler to the
  register access core. all signals are on clk_sys.
*/
`timescale 1ns/1ps
interface icra_pin_if;
  logic       start_det;
  logic       stop_det;
  logic       strobe_rise;
  logic       data_bit;
  logic [4:0] straps;

  modport sampler (output start_det, stop_det, strobe_rise, data_bit,
                   straps);
  modport core    (input  start_det, stop_det, strobe_rise, data_bit,
                   straps);
endinterface : icra_pin_if

// ===== core/icra_pin_sampler.sv
/*
  two-stage synchronisers for strobe, data-in and strap pins, plus
  start, stop and strobe edge detection. assumes the link clock is
  much slower than clk_sys.
*/
`timescale 1ns/1ps
module icra_pin_sampler
  import icra_pkg::*;
(
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   reset_n,
  // pins
  input  wire logic   ssi_strobe,
  input  wire logic   ssi_datain,
  input  wire logic [4:0] strap_pins,
  // to core
  icra_pin_if.sampler pins
);

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [1:0] prev;
  } icra_smp_s;

  icra_smp_s st_r;
  icra_smp_s st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.s1   = {strap_pins, ssi_strobe, ssi_datain};
    st_nxt.s2   = st_r.s1;
    st_nxt.prev = st_r.s2[1:0];
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // edges only from the second stage, never the first
  assign pins.strobe_rise = st_r.s2[1] & ~st_r.prev[1];
  assign pins.start_det   = st_r.s2[1] & st_r.prev[1] &
                            st_r.prev[0] & ~st_r.s2[0];
  assign pins.stop_det    = st_r.s2[1] & st_r.prev[1] &
                            ~st_r.prev[0] & st_r.s2[0];
  assign pins.data_bit    = st_r.s2[0];
  assign pins.straps      = st_r.s2[6:2];

endmodule : icra_pin_sampler

// ===== core/icra_pkg.sv
/*
  constants and the state encoding shared by the indirect
  configuration register access block and its pin sampler.
  assumes a single device clock and an active low async reset.
*/
package icra_pkg;

  // direct addresses on the serial management link
  localparam logic [2:0]  REG_INDEX_ADDR = 3'h0;
  localparam logic [2:0]  REG_DATA_ADDR  = 3'h2;
  localparam logic [2:0]  REG_FRAME_ADDR = 3'h3;
  localparam logic [2:0]  REG_CTRL_ADDR  = 3'h7;

  // index word layout
  localparam int          IDX_AUTO_BIT   = 15;
  localparam int          IDX_PAIR_BIT   = 14;
  localparam logic [15:0] IDX_RSVD_MASK  = 16'h3000;
  localparam logic [15:0] INDEX_RESET    = 16'h0000;

  // widths
  localparam int          CFG_ADDR_W     = 12;
  localparam int          CFG_DATA_W     = 8;
  localparam int          DEV_ID_W       = 3;

  // field counts on the link, in bits
  localparam logic [4:0]  ID_BITS        = 5'd3;
  localparam logic [4:0]  ADDR_BITS      = 5'd3;
  localparam logic [4:0]  BYTE_BITS      = 5'd8;
  localparam logic [4:0]  WORD_BITS      = 5'd16;

  // global control register and its bits
  localparam logic [11:0] GCR_IDX        = 12'h0f00;
  localparam int          GCR_INIT_BIT   = 4;
  localparam int          GCR_CHECK_BIT  = 0;

  // port number of the cpu-facing mac
  localparam logic [3:0]  CPU_PORT_NUM   = 4'h8;

  // strap capture waits for the synchroniser to fill
  localparam logic [1:0]  STRAP_WAIT     = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ID, ST_ADDR, ST_RW, ST_WDATA, ST_WR_HI, ST_RDATA, ST_SKIP
  } icra_state_e;

endpackage : icra_pkg

// ===== testbench/icra_core_test.sv
/*
  self-checking bench for the register access core: the host model
  drives the link, reads and frame bytes are scored from queues.
  assumes straps are held from reset release until the core takes them four clk_sys cycles later.
*/
`timescale 1ns/1ps
module icra_core_test
  import icra_pkg::*;
;
  localparam logic [2:0] ID = 3'h5;
  logic        clk_sys    = 1'b0;
  logic        reset_n    = 1'b0;
  logic [4:0]  strap_pins = 5'h15;
  logic        ee_done    = 1'b0;
  logic        ee_valid   = 1'b0;
  logic [11:0] ee_addr    = 12'h000;
  logic [7:0]  ee_data    = 8'h00;
  logic        strobe, datain, dout, dout_oe, ee_ready, unmanaged;
  logic        sw_en, frm_en, irq_en, chk_start, frm_valid, frm_ctrl;
  logic        rej, rd_valid;
  logic [3:0]  port_num;
  logic [7:0]  frm_byte;
  logic [15:0] rd_word;
  int          fail_count  = 0;
  int          check_count = 0;
  int          chk_cnt     = 0;
  int          rej_cnt     = 0;
  int          seed        = 74565;
  logic [15:0] rq[$];
  logic [15:0] fq[$];
  logic [7:0]  b[4];

  always #5 clk_sys = ~clk_sys;

  icra_core icra_core_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .ssi_strobe(strobe),
    .ssi_datain(datain), .ssi_dataout(dout), .ssi_dataout_oe(dout_oe),
    .strap_pins(strap_pins), .eeprom_boot_done(ee_done),
    .eeprom_wr_valid(ee_valid), .eeprom_wr_addr(ee_addr),
    .eeprom_wr_data(ee_data), .eeprom_wr_ready(ee_ready),
    .unmanaged_mode(unmanaged), .switching_enable(sw_en),
    .frame_path_enable(frm_en), .irq_path_enable(irq_en),
    .self_check_start(chk_start), .cpu_port_number(port_num),
    .frame_byte(frm_byte), .frame_byte_valid(frm_valid),
    .frame_byte_is_ctrl(frm_ctrl), .ctrl_frame_reject(rej));

  icra_host_model icra_host_model_i (
    .clk_sys(clk_sys), .ssi_strobe(strobe), .ssi_datain(datain),
    .ssi_dataout(dout), .ssi_dataout_oe(dout_oe),
    .rd_word(rd_word), .rd_valid(rd_valid));

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic complete_run();
    $display("checks=%0d failures=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic cmd(input logic [2:0] a, input logic r,
                     input logic [15:0] d, input int n);
    icra_host_model_i.xfer(ID, a, r, d, n);
  endtask : cmd

  task automatic rd(input logic [2:0] a, input logic [15:0] e,
                    input int n);
    rq.push_back(e);
    cmd(a, 1'b1, 16'h0000, n);
  endtask : rd

  task automatic do_reset(input logic [4:0] s);
    @(posedge clk_sys);
    reset_n    <= 1'b0;
    strap_pins <= s;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask : do_reset

  // valid held until the core takes the byte
  task automatic ee_wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    ee_valid <= 1'b1;
    ee_addr  <= a;
    ee_data  <= d;
    @(posedge clk_sys);
    while (ee_ready !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20)
    begin
      fail_count++;
      complete_run();
    end
    ee_valid <= 1'b0;
  endtask : ee_wr

  always @(posedge clk_sys)
  begin
    if (chk_start === 1'b1)
      chk_cnt++;
    if (rej === 1'b1)
      rej_cnt++;
    if (rd_valid === 1'b1)
      cmp(rd_word, rq.size() ? rq.pop_front() : 16'hxxxx);
    if (frm_valid === 1'b1)
      cmp({7'h00, frm_ctrl, frm_byte},
          fq.size() ? fq.pop_front() : 16'hxxxx);
  end

  initial
  begin
    #900_000;
    fail_count++;
    complete_run();
  end

  initial
  begin
    do_reset(5'h15);
    cmp({12'h000, port_num}, 16'h0008);
    cmp({13'h0, unmanaged, frm_en, irq_en}, 16'h0003);
    cmp({15'h0, sw_en}, 16'h0000);
    cmp(16'(chk_cnt), 16'h0001);
    b[0] = 8'($random(seed));
    cmd(3'h0, 1'b0, 16'h0010, 16);
    cmd(3'h2, 1'b0, {8'h00, b[0]}, 8);
    icra_host_model_i.xfer(3'h2, 3'h2, 1'b0, {8'h00, ~b[0]}, 8);
    cmd(3'h5, 1'b0, {8'h00, ~b[0]}, 8);
    rd(3'h2, {8'h00, b[0]}, 8);
    cmd(3'h0, 1'b0, 16'hfabc, 16);
    rd(3'h0, 16'hcabc, 16);
    b[1] = 8'($random(seed));
    b[2] = 8'($random(seed));
    cmd(3'h0, 1'b0, 16'h4020, 16);
    cmd(3'h2, 1'b0, {b[1], b[2]}, 16);
    cmd(3'h0, 1'b0, 16'h8020, 16);
    rd(3'h2, {8'h00, b[2]}, 8);
    rd(3'h2, {8'h00, b[1]}, 8);
    cmd(3'h0, 1'b0, 16'h8030, 16);
    for (int i = 0; i < 4; i++)
    begin
      b[i] = 8'($random(seed));
      cmd(3'h2, 1'b0, {8'h00, b[i]}, 8);
    end
    cmd(3'h0, 1'b0, 16'h0033, 16);
    rd(3'h2, {8'h00, b[3]}, 8);
    cmd(3'h0, 1'b0, 16'h8030, 16);
    for (int i = 0; i < 3; i++)
      rd(3'h2, {8'h00, b[i]}, 8);
    fq.push_back({8'h00, b[0]});
    fq.push_back({8'h00, b[1]});
    cmd(3'h3, 1'b0, {b[0], b[1]}, 16);
    fq.push_back({8'h01, b[2]});
    cmd(3'h7, 1'b0, {8'h00, b[2]}, 8);
    cmd(3'h0, 1'b0, 16'h0f00, 16);
    cmd(3'h2, 1'b0, 16'h0001, 8);
    cmp(16'(chk_cnt), 16'h0002);
    cmp({15'h0, sw_en}, 16'h0000);
    cmd(3'h2, 1'b0, 16'h0010, 8);
    cmp({15'h0, sw_en}, 16'h0001);
    // unmanaged with boot loader still running
    do_reset(5'h0d);
    cmp({12'h0, unmanaged, frm_en, irq_en, sw_en}, 16'h0009);
    b[0] = 8'($random(seed));
    ee_wr(12'h040, b[0]);
    @(posedge clk_sys);
    ee_done <= 1'b1;
    cmd(3'h0, 1'b0, 16'h0040, 16);
    rd(3'h2, {8'h00, b[0]}, 8);
    cmd(3'h7, 1'b0, 16'h00c3, 8);
    cmp(16'(rej_cnt), 16'h0001);
    repeat (20) @(posedge clk_sys);
    if (rq.size() + fq.size() != 0)
      fail_count++;
    complete_run();
  end
endmodule : icra_core_test

// ===== testbench/icra_host_model.sv
/*
  host model for the serial management link: start, id, address,
  r/w, data msb first, stop; scores read bits into rd_word.
  assumes idle-high pins with pull-ups and a 125 ns strobe period.
*/
`timescale 1ns/1ps
module icra_host_model
(
  // clock
  input  wire logic   clk_sys,
  // link pins
  output logic        ssi_strobe,
  output logic        ssi_datain,
  input  wire logic   ssi_dataout,
  input  wire logic   ssi_dataout_oe,
  // read result
  output logic [15:0] rd_word,
  output logic        rd_valid
);
  localparam realtime HALF = 62.5;

  initial
  begin
    ssi_strobe = 1'b1;
    ssi_datain = 1'b1;
    rd_word    = 16'h0000;
    rd_valid   = 1'b0;
  end

  // data moves mid-low so it never looks like start or stop
  task automatic send_bit(input logic v);
    ssi_strobe = 1'b0;
    #(HALF / 2);
    ssi_datain = v;
    #(HALF / 2);
    ssi_strobe = 1'b1;
    #HALF;
  endtask : send_bit

  task automatic xfer(input logic [2:0] id, input logic [2:0] addr,
                      input logic rd, input logic [15:0] wdata,
                      input int nbits);
    logic [15:0] acc;
    acc = 16'h0000;
    ssi_datain = 1'b0;
    #HALF;
    for (int i = 2; i >= 0; i--)
      send_bit(id[i]);
    for (int i = 2; i >= 0; i--)
      send_bit(addr[i]);
    send_bit(rd);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      if (rd)
      begin
        ssi_strobe = 1'b0;
        #HALF;
        // undriven read data scores as unknown
        acc = {acc[14:0], ssi_dataout_oe ? ssi_dataout : 1'bx};
        ssi_strobe = 1'b1;
        #HALF;
      end
      else
        send_bit(wdata[i]);
    end
    send_bit(1'b0);
    ssi_datain = 1'b1;
    #HALF;
    if (rd)
    begin
      @(posedge clk_sys);
      rd_word  <= acc;
      rd_valid <= 1'b1;
      @(posedge clk_sys);
      rd_valid <= 1'b0;
    end
  endtask : xfer
endmodule : icra_host_model
